// *** rtl/flash_block_erase_protect.sv ***
`timescale 1ns/10ps
// Function
// R1: 256 KB array; every access passes through this protection logic.
// R2: Erase clears one 1-KB unit only, leaving other units untouched.
// R3: Erased unit reads back as all ones.
// R4: Protection settings held per 2-KB region of two erase units.
// R5: Each region is open, read-only or execute-only.
// R6: Read-only regions refuse erase and program.
// R7: Execute-only regions refuse erase and program.
// R8: Execute-only regions serve fetches and deny processor data reads.
// R9: Execute-only regions deny debugger reads.
// R10: Any protection refusal raises a sticky violation flag.
module flash_block_erase_protect (
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire flash_prot_pkg::acc_req_t req_i,
	output logic ready_o,
	output flash_prot_pkg::acc_rsp_t rsp_o,
	input wire logic [flash_prot_pkg::REGIONS-1:0] ro_region_i,
	input wire logic [flash_prot_pkg::REGIONS-1:0] xo_region_i,
	input wire logic viol_clr_i,
	output logic viol_o,
	output logic busy_o
);

	typedef struct packed {
		flash_prot_pkg::ctl_state_t st;
		logic [flash_prot_pkg::UNIT_IDX_W-1:0] unit;
		logic [flash_prot_pkg::UNIT_LSB-1:0] cnt;
		logic rsp_valid;
		logic rsp_denied;
		logic viol;
	} ctl_t;

	ctl_t cur_ff;
	ctl_t nxt_ff;

	logic take;
	logic deny;
	logic [flash_prot_pkg::REGION_IDX_W-1:0] reg_idx;
	logic mem_we;
	logic [flash_prot_pkg::ADDR_W-1:0] mem_waddr;
	logic [flash_prot_pkg::DATA_W-1:0] mem_wdata;
	logic mem_re;
	logic [flash_prot_pkg::DATA_W-1:0] mem_rdata;

	////////////////////////////////////////////////////////////////////////
	// Region of a word address: two erase units share one setting
	function automatic logic [flash_prot_pkg::REGION_IDX_W-1:0] region_of(
		input logic [flash_prot_pkg::ADDR_W-1:0] a);
		region_of = a[flash_prot_pkg::ADDR_W-1:flash_prot_pkg::REGION_LSB]; // R4
	endfunction : region_of

	// Decide whether an access kind is blocked by the region setting
	function automatic logic blocked(input flash_prot_pkg::acc_kind_t k,
		input logic ro, input logic xo);
		logic modify;
		logic peek;
		modify = (k == flash_prot_pkg::ACC_PROGRAM) ||
			(k == flash_prot_pkg::ACC_ERASE);
		peek = (k == flash_prot_pkg::ACC_DATA_RD) ||
			(k == flash_prot_pkg::ACC_DEBUG_RD);
		// Both settings set counts as execute-only, the stricter one
		blocked = (modify && ro) || // R6
			(modify && xo) || // R7
			(peek && xo); // R8 R9
	endfunction : blocked

	////////////////////////////////////////////////////////////////////////
	// Request acceptance and protection check
	assign ready_o = (cur_ff.st == flash_prot_pkg::ST_IDLE);
	assign busy_o = (cur_ff.st == flash_prot_pkg::ST_ERASE);
	assign take = req_i.valid && ready_o; // R1
	assign reg_idx = region_of(req_i.addr);
	assign deny = blocked(req_i.kind, ro_region_i[reg_idx],
		xo_region_i[reg_idx]); // R5

	// Memory controls: erase walk owns the write port while busy
	always_comb begin
		mem_we = 1'b0;
		mem_waddr = req_i.addr;
		mem_wdata = req_i.wdata;
		mem_re = 1'b0;
		if (cur_ff.st == flash_prot_pkg::ST_ERASE) begin
			mem_we = 1'b1;
			mem_waddr = {cur_ff.unit, cur_ff.cnt}; // R2
			mem_wdata = flash_prot_pkg::ERASED_WORD; // R3
		end else if (take && !deny) begin
			mem_we = (req_i.kind == flash_prot_pkg::ACC_PROGRAM);
			mem_re = (req_i.kind == flash_prot_pkg::ACC_FETCH) ||
				(req_i.kind == flash_prot_pkg::ACC_DATA_RD) ||
				(req_i.kind == flash_prot_pkg::ACC_DEBUG_RD);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		nxt_ff = cur_ff;
		nxt_ff.rsp_valid = 1'b0;
		nxt_ff.rsp_denied = 1'b0;
		// Clear first so a refusal in the same cycle still sets the flag
		if (viol_clr_i) begin
			nxt_ff.viol = 1'b0;
		end
		unique case (cur_ff.st)
			flash_prot_pkg::ST_IDLE: begin
				if (take) begin
					if (deny) begin
						nxt_ff.rsp_valid = 1'b1;
						nxt_ff.rsp_denied = 1'b1;
						nxt_ff.viol = 1'b1; // R10
					end else if (req_i.kind == flash_prot_pkg::ACC_ERASE) begin
						nxt_ff.st = flash_prot_pkg::ST_ERASE;
						nxt_ff.unit = req_i.addr[flash_prot_pkg::ADDR_W-1:
							flash_prot_pkg::UNIT_LSB]; // R2
						nxt_ff.cnt = flash_prot_pkg::CNT_RESET;
					end else begin
						nxt_ff.rsp_valid = 1'b1;
					end
				end
			end
			flash_prot_pkg::ST_ERASE: begin
				nxt_ff.cnt = cur_ff.cnt + 1'b1;
				if (cur_ff.cnt == flash_prot_pkg::CNT_LAST) begin
					nxt_ff.st = flash_prot_pkg::ST_IDLE;
					nxt_ff.rsp_valid = 1'b1;
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cur_ff <= '{st: flash_prot_pkg::ST_IDLE,
				unit: flash_prot_pkg::UNIT_RESET,
				cnt: flash_prot_pkg::CNT_RESET,
				rsp_valid: 1'b0, rsp_denied: 1'b0, viol: 1'b0};
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Flash array; a refused read clears the data register
	flash_word_array u_array (
		.mclk_i(mclk_i),
		.we_i(mem_we),
		.waddr_i(mem_waddr),
		.wdata_i(mem_wdata),
		.re_i(mem_re),
		.clr_i(take && deny),
		.raddr_i(req_i.addr),
		.rdata_o(mem_rdata)
	);

	assign rsp_o.valid = cur_ff.rsp_valid;
	assign rsp_o.denied = cur_ff.rsp_denied;
	assign rsp_o.rdata = mem_rdata;
	assign viol_o = cur_ff.viol;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);

	logic wr_is_prog;
	assign wr_is_prog = mem_we && (cur_ff.st == flash_prot_pkg::ST_IDLE);

	ro_no_write_a: assert property ( // R6
		wr_is_prog |-> !ro_region_i[region_of(mem_waddr)])
		else $error("program reached a read-only region");
	xo_no_write_a: assert property ( // R7
		mem_we && !(cur_ff.st == flash_prot_pkg::ST_ERASE) |->
		!xo_region_i[region_of(mem_waddr)])
		else $error("program reached an execute-only region");
	xo_data_deny_a: assert property ( // R8
		take && req_i.kind == flash_prot_pkg::ACC_DATA_RD &&
		xo_region_i[reg_idx] |=> rsp_o.valid && rsp_o.denied &&
		rsp_o.rdata == '0)
		else $error("data read of execute-only region not denied");
	xo_fetch_ok_a: assert property ( // R8
		take && req_i.kind == flash_prot_pkg::ACC_FETCH |=>
		rsp_o.valid && !rsp_o.denied)
		else $error("instruction fetch was denied");
	xo_debug_deny_a: assert property ( // R9
		take && req_i.kind == flash_prot_pkg::ACC_DEBUG_RD &&
		xo_region_i[reg_idx] |=> rsp_o.valid && rsp_o.denied)
		else $error("debug read of execute-only region not denied");
	viol_set_a: assert property ( // R10
		rsp_o.denied |-> viol_o)
		else $error("refusal did not raise violation flag");
	erase_len_a: assert property ( // R2
		take && !deny && req_i.kind == flash_prot_pkg::ACC_ERASE |->
		##1 !ready_o [*8] ##249 rsp_o.valid && !rsp_o.denied && ready_o)
		else $error("erase did not finish in one unit walk");
	// Erase walk: starts at the unit base, steps one word a cycle, and
	// never carries into the unit bits, so neighbours stay untouched
	erase_ones_a: assert property ( // R3
		busy_o |-> mem_we && mem_wdata == flash_prot_pkg::ERASED_WORD)
		else $error("erase walk did not write all ones");
	erase_start_a: assert property ( // R2
		take && !deny && req_i.kind == flash_prot_pkg::ACC_ERASE |=>
		mem_waddr == {$past(req_i.addr[flash_prot_pkg::ADDR_W-1:
		flash_prot_pkg::UNIT_LSB]), flash_prot_pkg::CNT_RESET})
		else $error("erase walk did not start at its unit base");
	erase_step_a: assert property ( // R2
		busy_o && $past(busy_o) |-> mem_waddr == $past(mem_waddr) + 1'b1)
		else $error("erase walk left its unit or skipped a word");
	viol_hold_a: assert property ( // R10
		viol_o && !viol_clr_i |=> viol_o)
		else $error("violation flag dropped without a clear");

	erase_done_c: cover property (busy_o ##1 !busy_o);
	erase_refused_c: cover property (take && deny &&
		req_i.kind == flash_prot_pkg::ACC_ERASE);
	fetch_xo_c: cover property (take && xo_region_i[reg_idx] &&
		req_i.kind == flash_prot_pkg::ACC_FETCH);
	denied_c: cover property (rsp_o.valid && rsp_o.denied);
	program_c: cover property (wr_is_prog);

endmodule : flash_block_erase_protect

// *** rtl/flash_prot_pkg.sv ***
package flash_prot_pkg;

	// Array geometry, in bytes and in 32-bit words
	localparam int FLASH_BYTES = 256 * 1024;
	localparam int UNIT_BYTES = 1024;
	localparam int REGION_BYTES = 2048;
	localparam int WORD_BYTES = 4;
	localparam int WORDS = FLASH_BYTES / WORD_BYTES;
	localparam int ADDR_W = $clog2(WORDS);
	localparam int UNIT_WORDS = UNIT_BYTES / WORD_BYTES;
	localparam int UNIT_LSB = $clog2(UNIT_WORDS);
	localparam int REGION_LSB = $clog2(REGION_BYTES / WORD_BYTES);
	localparam int REGIONS = FLASH_BYTES / REGION_BYTES;
	localparam int UNIT_IDX_W = ADDR_W - UNIT_LSB;
	localparam int REGION_IDX_W = ADDR_W - REGION_LSB;
	localparam int DATA_W = 32;

	// Values after reset and erase
	localparam logic [DATA_W-1:0] ERASED_WORD = 32'hffffffff;
	localparam logic [UNIT_LSB-1:0] CNT_RESET = 8'h00;
	localparam logic [UNIT_LSB-1:0] CNT_LAST = 8'hff;
	localparam logic [UNIT_IDX_W-1:0] UNIT_RESET = 8'h00;

	// Erase walk keeps the array busy one cycle per word of the unit
	localparam int ERASE_CYCLES = UNIT_WORDS;

	typedef enum logic [2:0] {
		ACC_FETCH,
		ACC_DATA_RD,
		ACC_DEBUG_RD,
		ACC_PROGRAM,
		ACC_ERASE
	} acc_kind_t;

	typedef enum logic {
		ST_IDLE,
		ST_ERASE
	} ctl_state_t;

	typedef struct packed {
		logic valid;
		acc_kind_t kind;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} acc_req_t;

	typedef struct packed {
		logic valid;
		logic denied;
		logic [DATA_W-1:0] rdata;
	} acc_rsp_t;

endpackage : flash_prot_pkg

// *** rtl/flash_word_array.sv ***
`timescale 1ns/10ps
module flash_word_array (
	input wire logic mclk_i,
	input wire logic we_i,
	input wire logic [flash_prot_pkg::ADDR_W-1:0] waddr_i,
	input wire logic [flash_prot_pkg::DATA_W-1:0] wdata_i,
	input wire logic re_i,
	input wire logic clr_i,
	input wire logic [flash_prot_pkg::ADDR_W-1:0] raddr_i,
	output logic [flash_prot_pkg::DATA_W-1:0] rdata_o
);

	logic [flash_prot_pkg::DATA_W-1:0] mem_ff [flash_prot_pkg::WORDS];

	////////////////////////////////////////////////////////////////////////
	// Write port; no reset, contents survive like real flash
	always_ff @(posedge mclk_i) begin
		if (we_i) begin
			mem_ff[waddr_i] <= wdata_i;
		end
	end

	// Registered read; clear hides stale data behind a refused read
	always_ff @(posedge mclk_i) begin
		if (re_i) begin
			rdata_o <= mem_ff[raddr_i];
		end else if (clr_i) begin
			rdata_o <= '0;
		end
	end

endmodule : flash_word_array

// *** test/acc_requester.sv ***
`timescale 1ns/10ps
module acc_requester (
	input wire logic mclk_i,
	input wire logic go_i,
	input wire flash_prot_pkg::acc_kind_t kind_i,
	input wire logic [flash_prot_pkg::ADDR_W-1:0] addr_i,
	input wire logic [flash_prot_pkg::DATA_W-1:0] wdata_i,
	input wire logic ready_i,
	output flash_prot_pkg::acc_req_t req_o
);
	initial req_o = '0;
	// Request stands until the taking edge; data is inverted once there, then held
	always @(posedge mclk_i) begin
		if (go_i) begin
			req_o <= '{1'b1, kind_i, addr_i, wdata_i};
		end else if (req_o.valid && ready_i) begin
			req_o.valid <= 1'b0;
			req_o.wdata <= ~req_o.wdata;
		end
	end
endmodule : acc_requester

// *** test/test_flash_block_erase_protect.sv ***
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
	n_mismatch++; $display("BAD %0t %h %h", $time, a, b); end end
module test_flash_block_erase_protect;
	logic mclk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic go = 1'b0;
	flash_prot_pkg::acc_kind_t kd = flash_prot_pkg::ACC_FETCH;
	logic [15:0] ad = 16'h0000;
	logic [31:0] wd = 32'h00000000;
	logic [127:0] ro = 128'h0;
	logic [127:0] xo = 128'h0;
	logic clr = 1'b0;
	logic ready;
	logic viol;
	logic busy;
	flash_prot_pkg::acc_req_t req;
	flash_prot_pkg::acc_rsp_t rsp;
	int n_mismatch = 0;
	int samples_checked = 0;
	int waited = 0;
	int n_busy = 0;
	always #10 mclk_i = ~mclk_i;
	acc_requester acc_requester_inst (.mclk_i(mclk_i), .go_i(go),
		.kind_i(kd), .addr_i(ad), .wdata_i(wd), .ready_i(ready),
		.req_o(req));
	flash_block_erase_protect flash_block_erase_protect_inst (
		.mclk_i(mclk_i), .reset_n_i(reset_n_i), .req_i(req),
		.ready_o(ready), .rsp_o(rsp), .ro_region_i(ro), .xo_region_i(xo),
		.viol_clr_i(clr), .viol_o(viol), .busy_o(busy));
	////////////////////////////////////////////////////////////////////
	// One request, then wait (bounded, erase is the longest) for answer
	task automatic acc(input flash_prot_pkg::acc_kind_t k,
		input logic [15:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		go <= 1'b1;
		kd <= k;
		ad <= a;
		wd <= d;
		@(posedge mclk_i);
		go <= 1'b0;
		// Count answer latency and cycles spent busy with ready low
		waited = 0;
		n_busy = 0;
		while (waited < 400 && rsp.valid !== 1'b1) begin
			@(posedge mclk_i) #1;
			waited++;
			if (busy === 1'b1 && ready === 1'b0) begin
				n_busy++;
			end
		end
		// A request left unanswered counts against the run
		if (rsp.valid !== 1'b1) begin
			n_mismatch++;
		end
	endtask : acc
	// Read and compare the denial bit and the returned word
	task automatic rd(input flash_prot_pkg::acc_kind_t k,
		input logic [15:0] a, input logic den, input logic [31:0] exp);
		acc(k, a, 32'h0);
		`CHK(waited, 1)
		`CHK(rsp.denied, den)
		`CHK(rsp.rdata, exp)
	endtask : rd
	////////////////////////////////////////////////////////////////////
	// Erase clears one unit only; neighbour unit of the region survives
	task automatic t_erase;
		acc(flash_prot_pkg::ACC_PROGRAM, 16'h0005, 32'h12345678);
		rd(flash_prot_pkg::ACC_DATA_RD, 16'h0005, 1'b0, 32'h12345678);
		acc(flash_prot_pkg::ACC_PROGRAM, 16'hffff, 32'h600dcafe);
		rd(flash_prot_pkg::ACC_DATA_RD, 16'hffff, 1'b0, 32'h600dcafe);
		acc(flash_prot_pkg::ACC_PROGRAM, 16'h0105, 32'ha5a5a5a5);
		acc(flash_prot_pkg::ACC_ERASE, 16'h0010, 32'h0);
		`CHK(rsp.denied, 1'b0)
		`CHK(waited, flash_prot_pkg::ERASE_CYCLES + 1)
		`CHK(n_busy, flash_prot_pkg::ERASE_CYCLES)
		`CHK(ready, 1'b1)
		`CHK(busy, 1'b0)
		rd(flash_prot_pkg::ACC_DATA_RD, 16'h0005, 1'b0, 32'hffffffff);
		rd(flash_prot_pkg::ACC_DATA_RD, 16'h00ff, 1'b0, 32'hffffffff);
		rd(flash_prot_pkg::ACC_DATA_RD, 16'h0105, 1'b0, 32'ha5a5a5a5);
	endtask : t_erase
	// Read-only region: writes refused, flag raised, reads still served
	task automatic t_ro;
		acc(flash_prot_pkg::ACC_PROGRAM, 16'h0200, 32'h0badf00d);
		acc(flash_prot_pkg::ACC_PROGRAM, 16'h0400, 32'hc0de0001);
		@(posedge mclk_i);
		ro[1] <= 1'b1;
		xo[2] <= 1'b1;
		acc(flash_prot_pkg::ACC_PROGRAM, 16'h0300, 32'h0);
		`CHK(rsp.denied, 1'b1)
		`CHK(viol, 1'b1)
		acc(flash_prot_pkg::ACC_ERASE, 16'h0200, 32'h0);
		`CHK(rsp.denied, 1'b1)
		rd(flash_prot_pkg::ACC_DEBUG_RD, 16'h0200, 1'b0, 32'h0badf00d);
		@(posedge mclk_i);
		clr <= 1'b1;
		@(posedge mclk_i);
		clr <= 1'b0;
		@(posedge mclk_i) #1;
		`CHK(viol, 1'b0)
	endtask : t_ro
	// Execute-only region: only fetches served, all else refused
	task automatic t_xo;
		rd(flash_prot_pkg::ACC_FETCH, 16'h0400, 1'b0, 32'hc0de0001);
		rd(flash_prot_pkg::ACC_DATA_RD, 16'h0400, 1'b1, 32'h0);
		`CHK(viol, 1'b1)
		rd(flash_prot_pkg::ACC_DEBUG_RD, 16'h0400, 1'b1, 32'h0);
		acc(flash_prot_pkg::ACC_PROGRAM, 16'h0400, 32'h0);
		`CHK(rsp.denied, 1'b1)
		acc(flash_prot_pkg::ACC_ERASE, 16'h0400, 32'h0);
		`CHK(rsp.denied, 1'b1)
		rd(flash_prot_pkg::ACC_FETCH, 16'h0400, 1'b0, 32'hc0de0001);
	endtask : t_xo
	////////////////////////////////////////////////////////////////////
	task automatic complete_run;
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : complete_run
	// Main sequence after three reset cycles
	initial begin
		repeat (3) @(posedge mclk_i);
		reset_n_i <= 1'b1;
		t_erase();
		t_ro();
		t_xo();
		complete_run();
	end
	// A few erases plus short accesses need well under this span
	initial begin
		repeat (20000) @(posedge mclk_i);
		n_mismatch++;
		complete_run();
	end
endmodule : test_flash_block_erase_protect
